// ==== hdl/fmap_pkg.sv ====
package fmap_pkg;

  // Pointer geometry.
  localparam int unsigned LINE_W     = 9;
  localparam int unsigned BLOCK_W    = 4;
  localparam int unsigned BIT_W      = 6;
  localparam logic [8:0]  LAST_LINE  = 9'h131;
  localparam logic [9:0]  LINE_COUNT = 10'h132;
  localparam logic [3:0]  LAST_BLOCK = 4'hf;
  localparam logic [5:0]  LAST_BIT   = 6'h3b;

  // Read start delay and transfer pulse lengths, in port clock ticks.
  localparam logic [6:0]  READ_DLY_LAST = 7'h3f;
  localparam logic [2:0]  WR_SYNC_LEN   = 3'h5;
  localparam logic [2:0]  RD_SYNC_LEN   = 3'h4;

  localparam int unsigned NPORT = 3;

  // Register map, byte addresses.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PTR0 = 8'h04;
  localparam logic [7:0] OFS_PTR1 = 8'h08;
  localparam logic [7:0] OFS_PTR2 = 8'h0c;

  // Control register fields.
  localparam int unsigned CTRL_RECURSIVE = 0;
  localparam int unsigned CTRL_PRESET    = 1;
  localparam int unsigned CTRL_SYNC_ROLE = 2;
  localparam logic [2:0]  CTRL_RESET     = 3'h0;

  // Pointer status fields.
  localparam int unsigned PTR_LINE_LSB  = 0;
  localparam int unsigned PTR_BLOCK_LSB = 16;
  localparam int unsigned PTR_PROTECT   = 24;
  localparam int unsigned PTR_SYNC_IN   = 25;
  localparam int unsigned PTR_LC_PEND   = 26;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pointer controls of one port, sampled at each port clock tick.
  typedef struct packed {
    logic tick;
    logic line_clear;
    logic block_clear;
    logic line_step;
  } fmap_ctl_s;

  function automatic logic fmap_reg_hit(input logic [7:0] addr);
    fmap_reg_hit = (addr == OFS_CTRL) || (addr == OFS_PTR0) ||
                   (addr == OFS_PTR1) || (addr == OFS_PTR2);
  endfunction : fmap_reg_hit

endpackage : fmap_pkg

// ==== hdl/fmap_axil.sv ====
`timescale 1ns/1ns
`default_nettype none
module fmap_axil (
  input  wire logic        clk,           // System clock.
  input  wire logic        rstn,          // Synchronous reset, active low.
  input  wire logic [7:0]  s_awaddr,      // Write address.
  input  wire logic        s_awvalid,     // Write address valid.
  output logic             s_awready,     // Write address ready.
  input  wire logic [31:0] s_wdata,       // Write data.
  input  wire logic [3:0]  s_wstrb,       // Write byte strobes.
  input  wire logic        s_wvalid,      // Write data valid.
  output logic             s_wready,      // Write data ready.
  output logic [1:0]       s_bresp,       // Write response.
  output logic             s_bvalid,      // Write response valid.
  input  wire logic        s_bready,      // Write response ready.
  input  wire logic [7:0]  s_araddr,      // Read address.
  input  wire logic        s_arvalid,     // Read address valid.
  output logic             s_arready,     // Read address ready.
  output logic [31:0]      s_rdata,       // Read data.
  output logic [1:0]       s_rresp,       // Read response.
  output logic             s_rvalid,      // Read data valid.
  input  wire logic        s_rready,      // Read data ready.
  output logic             wr_stb,        // One-cycle register write.
  output logic [7:0]       wr_addr,       // Register write address.
  output logic [31:0]      wr_data,       // Register write data.
  output logic [3:0]       wr_strb,       // Register write strobes.
  input  wire logic [31:0] rd_data        // Read data for s_araddr.
);
  import fmap_pkg::*;

  logic aw_have_r;
  logic w_have_r;

  assign s_awready = ~aw_have_r & ~s_bvalid;
  assign s_wready  = ~w_have_r & ~s_bvalid;
  assign s_arready = ~s_rvalid;

  // Address and data are caught in either order; the write fires once both are held.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 32'h0;
      wr_strb   <= 4'h0;
    end else if (wr_stb) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_r <= 1'b1;
        wr_addr   <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have_r <= 1'b1;
        wr_data  <= s_wdata;
        wr_strb  <= s_wstrb;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_stb   <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp  <= RESP_OKAY;
    end else begin
      wr_stb <= aw_have_r && w_have_r && !wr_stb && !s_bvalid;
      if (wr_stb) begin
        s_bvalid <= 1'b1;
        s_bresp  <= fmap_reg_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0;
      s_rresp  <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= fmap_reg_hit(s_araddr) ? rd_data : 32'h0;
      s_rresp  <= fmap_reg_hit(s_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule : fmap_axil
`default_nettype wire

// ==== hdl/fmap_top.sv ====
// Behaviour
// - pointers hold line 0..305, block 0..15.
// - recursive mode walks all positions and wraps.
// - block clear keeps line, block zero.
// - block clear with steps: line v+n, block 0.
// - write line clear alone: line 0, block h+1.
// - write line clear with steps: v+n, h+1.
// - write both clears with steps: line n, block 0.
// - preset initial cycle: line 0, preset block.
// - preset block clear keeps line, loads block.
// - preset block clear with steps: v+n, preset.
// - read line clear resolves one block later.
// - write clear discards partial block.
// - preset low enables transfer sync; role selects master.
// - read block starts 64 ticks after clear.
// - read data protected until new block starts.
// - master drives write sync 5, read 4.
// - held control input counts only once.
// - write gate freezes the write port.
// - recursive mode ignores block clear.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module fmap_top (
  input  wire logic                         clk,              // System clock, 25 MHz.
  input  wire logic                         rstn,             // Synchronous reset, active low.
  input  wire logic [7:0]                   s_awaddr,         // AXI write address.
  input  wire logic                         s_awvalid,        // AXI write address valid.
  output logic                              s_awready,        // AXI write address ready.
  input  wire logic [31:0]                  s_wdata,          // AXI write data.
  input  wire logic [3:0]                   s_wstrb,          // AXI write strobes.
  input  wire logic                         s_wvalid,         // AXI write data valid.
  output logic                              s_wready,         // AXI write data ready.
  output logic [1:0]                        s_bresp,          // AXI write response.
  output logic                              s_bvalid,         // AXI write response valid.
  input  wire logic                         s_bready,         // AXI write response ready.
  input  wire logic [7:0]                   s_araddr,         // AXI read address.
  input  wire logic                         s_arvalid,        // AXI read address valid.
  output logic                              s_arready,        // AXI read address ready.
  output logic [31:0]                       s_rdata,          // AXI read data.
  output logic [1:0]                        s_rresp,          // AXI read response.
  output logic                              s_rvalid,         // AXI read data valid.
  input  wire logic                         s_rready,         // AXI read data ready.
  input  wire fmap_pkg::fmap_ctl_s [2:0]    port_ctl,         // Port 0 write, ports 1 and 2 read.
  input  wire logic                         write_gate,       // High freezes the write port.
  input  wire logic [3:0]                   block_preset_bus, // Preset block number.
  input  wire logic [2:0]                   sync_in,          // Sync pins, input side.
  output logic [2:0]                        sync_out,         // Sync pins, output side.
  output logic [2:0]                        sync_oe,          // Sync pins, high while driven.
  output logic [2:0][8:0]                   line_addr,        // Current line of each pointer.
  output logic [2:0][3:0]                   block_addr,       // Current block of each pointer.
  output logic [2:0]                        read_start,       // Read block output begins.
  output logic [2:0]                        read_protect,     // Read data held.
  output logic                              write_discard     // Partial write block dropped.
);
  import fmap_pkg::*;

  logic [2:0]  ctrl_r;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [31:0] rd_data;
  logic [2:0]  lc_pend_flag;

  wire recursive   = ctrl_r[CTRL_RECURSIVE];
  wire preset_mode = ctrl_r[CTRL_PRESET] & ~recursive;
  // Master drives the sync pins only while transfer synchronous mode is active.
  wire sync_master = ~ctrl_r[CTRL_PRESET] & ~ctrl_r[CTRL_SYNC_ROLE];

  // Line address plus a step count, folded back into 0..305.
  function automatic logic [8:0] line_add(input logic [8:0] v, input logic [8:0] n);
    logic [9:0] s;
    s = {1'b0, v} + {1'b0, n};
    if (s >= LINE_COUNT) begin
      s = s - LINE_COUNT;
    end
    if (s >= LINE_COUNT) begin
      s = s - LINE_COUNT;
    end
    line_add = s[8:0];
  endfunction : line_add

  // Block advance that stops at the last block of a line.
  function automatic logic [3:0] block_next(input logic [3:0] h);
    block_next = (h == LAST_BLOCK) ? LAST_BLOCK : h + 4'h1;
  endfunction : block_next

  fmap_axil u_axil (
    .clk       (clk),
    .rstn      (rstn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .rd_data   (rd_data)
  );

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_stb && wr_addr == OFS_CTRL && wr_strb[0]) begin
      ctrl_r <= wr_data[2:0];
    end
  end

  function automatic logic [31:0] ptr_word(input logic [1:0] p);
    logic [31:0] w;
    w = 32'h0;
    w[PTR_LINE_LSB +: 9]  = line_addr[p];
    w[PTR_BLOCK_LSB +: 4] = block_addr[p];
    w[PTR_PROTECT]        = read_protect[p];
    w[PTR_SYNC_IN]        = sync_in[p];
    w[PTR_LC_PEND]        = lc_pend_flag[p];
    ptr_word = w;
  endfunction : ptr_word

  always_comb begin
    case (s_araddr)
      OFS_CTRL: rd_data = {29'h0, ctrl_r};
      OFS_PTR0: rd_data = ptr_word(2'h0);
      OFS_PTR1: rd_data = ptr_word(2'h1);
      OFS_PTR2: rd_data = ptr_word(2'h2);
      default:  rd_data = 32'h0;
    endcase
  end

  logic [2:0] discard_vec;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      write_discard <= 1'b0;
    end else begin
      write_discard <= discard_vec[0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      localparam bit IS_WR = (g == 0);
      localparam logic [2:0] SYNC_LEN = IS_WR ? WR_SYNC_LEN : RD_SYNC_LEN;

      logic       lc_prev_r;
      logic       bc_prev_r;
      logic       st_prev_r;
      logic [5:0] bit_r;
      logic [8:0] step_r;
      logic [1:0] lc_pend_r;
      logic [6:0] dly_r;
      logic       dly_act_r;
      logic [2:0] sync_cnt_r;
      logic [8:0] line_nxt;
      logic [3:0] block_nxt;

      // The write gate stops the write port clock outright.
      wire tick  = port_ctl[g].tick & ~(IS_WR & write_gate);
      // A control counts only on its low-to-high change.
      wire lc_ev = tick & port_ctl[g].line_clear & ~lc_prev_r;
      wire bc_ev = tick & port_ctl[g].block_clear & ~bc_prev_r;
      wire st_ev = tick & port_ctl[g].line_step & ~st_prev_r;
      wire bc_eff   = bc_ev & ~recursive;
      wire lc_rec   = lc_ev & recursive;
      wire lc_nrec  = lc_ev & ~recursive;
      wire blk_end  = tick & (bit_r == LAST_BIT);
      // A step together with a clear is void, except a read step with a block clear.
      wire st_eff   = st_ev & ~recursive & ~lc_ev & ~(bc_ev & IS_WR);
      wire [8:0] n_bc = step_r + {8'h0, ~IS_WR & st_ev & bc_eff};
      wire lc_done  = blk_end & (lc_pend_r == 2'h1);
      wire [3:0] preset_blk = preset_mode ? block_preset_bus : 4'h0;

      assign lc_pend_flag[g] = (lc_pend_r != 2'h0);

      always_ff @(posedge clk) begin
        if (!rstn) begin
          lc_prev_r <= 1'b0;
          bc_prev_r <= 1'b0;
          st_prev_r <= 1'b0;
        end else if (tick) begin
          lc_prev_r <= port_ctl[g].line_clear;
          bc_prev_r <= port_ctl[g].block_clear;
          st_prev_r <= port_ctl[g].line_step;
        end
      end

      // Position inside the 60-bit block; a block clear, or a line clear in recursive mode, restarts the block at once.
      always_ff @(posedge clk) begin
        if (!rstn) begin
          bit_r <= 6'h0;
        end else if (tick) begin
          if (lc_rec || bc_eff) begin
            bit_r <= 6'h1;
          end else if (bit_r == LAST_BIT) begin
            bit_r <= 6'h0;
          end else begin
            bit_r <= bit_r + 6'h1;
          end
        end
      end

      assign discard_vec[g] = IS_WR & (lc_rec | bc_eff) & (bit_r != 6'h0);

      // Line steps are counted from the last clear.
      always_ff @(posedge clk) begin
        if (!rstn) begin
          step_r <= 9'h0;
        end else if (bc_eff || lc_nrec || lc_done) begin
          step_r <= 9'h0;
        end else if (st_eff && step_r != LAST_LINE) begin
          step_r <= step_r + 9'h1;
        end
      end

      // A nonrecursive line clear waits for one block end on write, two on read.
      always_ff @(posedge clk) begin
        if (!rstn) begin
          lc_pend_r <= 2'h0;
        end else if (bc_eff) begin
          lc_pend_r <= 2'h0;
        end else if (lc_nrec) begin
          lc_pend_r <= IS_WR ? 2'h1 : 2'h2;
        end else if (blk_end && lc_pend_r != 2'h0) begin
          lc_pend_r <= lc_pend_r - 2'h1;
        end
      end

      always_comb begin
        line_nxt  = line_addr[g];
        block_nxt = block_addr[g];
        if (lc_rec) begin
          line_nxt  = 9'h0;
          block_nxt = 4'h0;
        end else if (bc_eff) begin
          if (lc_pend_r != 2'h0 || lc_nrec) begin
            line_nxt = n_bc;
          end else begin
            line_nxt = line_add(line_addr[g], n_bc);
          end
          block_nxt = preset_blk;
        end else if (lc_done) begin
          if (IS_WR && !preset_mode && step_r != 9'h0) begin
            line_nxt = line_add(line_addr[g], step_r);
          end else begin
            line_nxt = step_r;
          end
          block_nxt = block_next(block_addr[g]);
        end else if (blk_end) begin
          if (recursive) begin
            if (block_addr[g] == LAST_BLOCK) begin
              block_nxt = 4'h0;
              line_nxt  = (line_addr[g] == LAST_LINE) ? 9'h0 : line_addr[g] + 9'h1;
            end else begin
              block_nxt = block_addr[g] + 4'h1;
            end
          end else begin
            block_nxt = block_next(block_addr[g]);
          end
        end
      end

      always_ff @(posedge clk) begin
        if (!rstn) begin
          line_addr[g]  <= 9'h0;
          block_addr[g] <= 4'h0;
        end else begin
          line_addr[g]  <= line_nxt;
          block_addr[g] <= block_nxt;
        end
      end

      // Read output of the newly addressed block begins 64 ticks after its clear.
      always_ff @(posedge clk) begin
        if (!rstn) begin
          dly_r           <= 7'h0;
          dly_act_r       <= 1'b0;
          read_start[g]   <= 1'b0;
          read_protect[g] <= 1'b0;
        end else begin
          read_start[g] <= 1'b0;
          if (!IS_WR && (recursive ? lc_ev : bc_eff)) begin
            dly_r           <= 7'h0;
            dly_act_r       <= 1'b1;
            read_protect[g] <= 1'b1;
          end else if (dly_act_r && tick) begin
            if (dly_r == READ_DLY_LAST) begin
              dly_act_r       <= 1'b0;
              read_start[g]   <= 1'b1;
              read_protect[g] <= 1'b0;
            end else begin
              dly_r <= dly_r + 7'h1;
            end
          end
        end
      end

      // As master, each block transfer raises the sync pin for a fixed tick count.
      always_ff @(posedge clk) begin
        if (!rstn) begin
          sync_cnt_r  <= 3'h0;
          sync_out[g] <= 1'b0;
        end else if (!sync_master) begin
          sync_cnt_r  <= 3'h0;
          sync_out[g] <= 1'b0;
        end else if (blk_end) begin
          sync_cnt_r  <= SYNC_LEN - 3'h1;
          sync_out[g] <= 1'b1;
        end else if (tick) begin
          if (sync_cnt_r != 3'h0) begin
            sync_cnt_r <= sync_cnt_r - 3'h1;
          end else begin
            sync_out[g] <= 1'b0;
          end
        end
      end

      always_ff @(posedge clk) begin
        if (!rstn) begin
          sync_oe[g] <= 1'b0;
        end else begin
          sync_oe[g] <= sync_master;
        end
      end
    end
  endgenerate

endmodule : fmap_top
`default_nettype wire

// ==== tb/fmap_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module fmap_assertions (
  input  wire logic                      clk,           // Clock.
  input  wire logic                      rstn,          // Reset, low.
  input  wire logic                      s_bvalid,      // Write response valid.
  input  wire logic                      s_bready,      // Write response ready.
  input  wire logic [1:0]                s_bresp,       // Write response.
  input  wire logic                      s_arready,     // Read address ready.
  input  wire logic                      s_rvalid,      // Read data valid.
  input  wire logic                      s_rready,      // Read data ready.
  input  wire logic [31:0]               s_rdata,       // Read data.
  input  wire fmap_pkg::fmap_ctl_s [2:0] port_ctl,      // Port controls.
  input  wire logic                      write_gate,    // Write gate.
  input  wire logic [2:0][8:0]           line_addr,     // Lines.
  input  wire logic [2:0][3:0]           block_addr,    // Blocks.
  input  wire logic [2:0]                read_start,    // Read starts.
  input  wire logic [2:0]                read_protect,  // Read holds.
  input  wire logic                      write_discard  // Dropped block.
);
  import fmap_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Counts read port 1 ticks while its data is held.
  logic [6:0] dly_r;
  always_ff @(posedge clk) begin
    if (!rstn || !read_protect[1]) dly_r <= 7'h0;
    else if (port_ctl[1].tick) dly_r <= dly_r + 7'h1;
  end
  sequence b_wait; s_bvalid && !s_bready; endsequence
  sequence r_wait; s_rvalid && !s_rready; endsequence
  chk_bresp_hold: assert property (b_wait |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (r_wait |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  chk_ar_block: assert property (s_rvalid |-> !s_arready)
    else $error("read address taken while busy");
  chk_line_range: assert property (line_addr[0] <= LAST_LINE && line_addr[1] <= LAST_LINE && line_addr[2] <= LAST_LINE)
    else $error("line out of range");
  chk_ptr_freeze: assert property ($past(rstn) && !$past(port_ctl[0].tick && !write_gate) |-> $stable(line_addr[0]) && $stable(block_addr[0]))
    else $error("write pointer moved without tick");
  chk_discard_pulse: assert property (write_discard |=> !write_discard)
    else $error("discard longer than one cycle");
  chk_rs_none: assert property (!read_start[0])
    else $error("read start on write port");
  chk_read_delay: assert property (read_start[1] |-> dly_r == 7'h40)
    else $error("read start delay wrong");
  chk_protect_set: assert property (read_start[1] |-> $past(read_protect[1]))
    else $error("read start without hold");
endmodule : fmap_assertions
bind fmap_top fmap_assertions u_fmap_assertions (.clk, .rstn, .s_bvalid, .s_bready, .s_bresp,
  .s_arready, .s_rvalid, .s_rready, .s_rdata, .port_ctl, .write_gate, .line_addr,
  .block_addr, .read_start, .read_protect, .write_discard);
`default_nettype wire

// ==== tb/fmap_ctl_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module fmap_ctl_model (
  input  wire logic                      clk,       // Clock.
  input  wire logic                      rstn,      // Reset, low.
  input  wire logic                      cmd_valid, // Command request.
  input  wire logic [1:0]                cmd_port,  // Target port.
  input  wire logic [15:0]               cmd_n,     // Tick count.
  input  wire logic [2:0]                cmd_lvl,   // Clear, clear, step.
  input  wire logic                      slow,      // Tick every other clock.
  output logic                           busy,      // Ticks pending.
  output fmap_pkg::fmap_ctl_s [2:0]      port_ctl   // Port controls.
);
  import fmap_pkg::*;
  logic [15:0]     left_r;
  logic            ph_r;
  logic [1:0]      p_r;
  logic [2:0][2:0] lvl_r;
  assign busy = (left_r != 16'h0);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      left_r <= 16'h0;
      ph_r <= 1'b0;
      p_r <= 2'h0;
      lvl_r <= '0;
    end else if (!busy && cmd_valid) begin
      left_r <= cmd_n;
      p_r <= cmd_port;
      lvl_r[cmd_port] <= cmd_lvl;
      ph_r <= 1'b0;
    end else if (busy) begin
      ph_r <= slow ? ~ph_r : 1'b0;
      if (!slow || ph_r) left_r <= left_r - 16'h1;
    end
  end
  // Levels are only valid during a tick; elsewhere they show the inverse.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      port_ctl[i].tick = busy && (p_r == i[1:0]) && (!slow || ph_r);
      {port_ctl[i].line_clear, port_ctl[i].block_clear, port_ctl[i].line_step} =
        port_ctl[i].tick ? lvl_r[i] : ~lvl_r[i];
    end
  end
endmodule : fmap_ctl_model
`default_nettype wire

// ==== tb/field_memory_address_pointer_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module field_memory_address_pointer_tb;
  import fmap_pkg::*;
  logic clk, rstn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, write_gate, write_discard;
  logic cmd_valid, slow, busy;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [31:0] seed = 32'h266b65b4;
  logic [1:0] s_bresp, s_rresp, rsp, cmd_port;
  logic [2:0] sync_out, sync_oe, read_start, read_protect, cmd_lvl;
  logic [3:0] block_preset_bus, b;
  logic [15:0] cmd_n;
  logic [2:0][8:0] line_addr;
  logic [2:0][3:0] block_addr;
  fmap_ctl_s [2:0] port_ctl;
  int miscompares, tests_run, rs_cnt, wd_cnt, k, n, p, v, w0;
  fmap_top u_fmap_top (.clk, .rstn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .port_ctl,
    .write_gate, .block_preset_bus, .sync_in(3'h0), .sync_out, .sync_oe, .line_addr,
    .block_addr, .read_start, .read_protect, .write_discard);
  fmap_ctl_model u_fmap_ctl_model (.clk, .rstn, .cmd_valid, .cmd_port, .cmd_n, .cmd_lvl,
    .slow, .busy, .port_ctl);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] ptr_w(input logic [8:0] lv, input logic [3:0] bk);
    return {12'h0, bk, 7'h0, lv};
  endfunction : ptr_w
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cp(input int q, input logic [8:0] lv, input logic [3:0] bk);
    chk({line_addr[q], block_addr[q]}, {lv, bk});
  endtask : cp
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_awaddr <= a; s_wdata <= d; s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask : axr
  task automatic run(input int q, input int cnt, input logic [2:0] lvl);
    cmd_port <= q[1:0]; cmd_n <= cnt[15:0]; cmd_lvl <= lvl; cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do @(posedge clk); while (busy);
  endtask : run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("[FAIL] %0t timeout", $time);
    print_verdict();
  end
  always @(posedge clk) begin
    rs_cnt <= rs_cnt + read_start[1] + read_start[2];
    wd_cnt <= wd_cnt + write_discard;
  end
  initial begin
    {rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, write_gate} = '0;
    {s_awaddr, s_araddr, s_wdata, block_preset_bus} = '0;
    {cmd_valid, cmd_port, cmd_n, cmd_lvl, slow, rs_cnt, wd_cnt} = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    axr(OFS_CTRL, rd, rsp); chk(rd, 32'h0);
    axr(OFS_PTR0, rd, rsp); chk(rd, ptr_w(9'h0, 4'h0));
    axr(8'h10, rd, rsp); chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
    axw(8'h10, 32'h7, rsp); chk(rsp, RESP_SLVERR);
    chk(sync_oe, 3'h7);
    axw(OFS_CTRL, 32'h4, rsp); repeat (2) @(posedge clk); chk(sync_oe, 3'h0);
    axr(OFS_CTRL, rd, rsp); chk(rd, 32'h4);
    axw(OFS_CTRL, 32'h0, rsp);
    $display("test registers done");
    run(0, 1, 3'h6); cp(0, 0, 0);
    run(0, 1020, 3'h0); cp(0, 0, 15);
    axr(OFS_PTR0, rd, rsp); chk(rd, ptr_w(9'h0, 4'hf));
    n = rnd() % 4 + 1;
    for (k = 0; k < n; k++) begin
      run(0, 2, 3'h1); run(0, 1, 3'h0);
    end
    run(0, 1, 3'h2); cp(0, n, 0);
    run(0, 130, 3'h0); cp(0, n, 2); run(0, 1, 3'h2); cp(0, n, 0);
    run(0, 59, 3'h0); w0 = wd_cnt; run(0, 1, 3'h2); repeat (3) @(posedge clk);
    chk(wd_cnt - w0, 0);
    run(0, 20, 3'h0); run(0, 1, 3'h2); repeat (3) @(posedge clk);
    chk(wd_cnt - w0, 1);
    write_gate <= 1'b1; run(0, 200, 3'h0); write_gate <= 1'b0; cp(0, n, 0);
    $display("test write port done");
    axw(OFS_CTRL, 32'h1, rsp); run(0, 1, 3'h4); cp(0, 0, 0);
    run(0, 1060, 3'h1); cp(0, 1, 1);
    run(0, 1, 3'h2); cp(0, 1, 1);
    $display("test recursive done");
    axw(OFS_CTRL, 32'h2, rsp); repeat (2) @(posedge clk); chk(sync_oe, 3'h0);
    run(0, 1, 3'h0); b = 4'(rnd()); block_preset_bus <= b;
    run(0, 1, 3'h6); cp(0, 0, b); run(0, 1, 3'h0);
    v = 0;
    repeat (3) begin
      n = rnd() % 3;
      for (k = 0; k < n; k++) begin
        run(0, 1, 3'h1); run(0, 1, 3'h0);
      end
      b = 4'(rnd()); block_preset_bus <= b; v += n;
      run(0, 1, 3'h2); cp(0, v, b); run(0, 1, 3'h0);
    end
    $display("test preset done");
    axw(OFS_CTRL, 32'h0, rsp); slow <= 1'b1;
    for (p = 1; p < 3; p++) begin
      run(p, 1, 3'h0); run(p, 1, 3'h2); k = rs_cnt; cp(p, 0, 0);
      run(p, 63, 3'h0); chk(rs_cnt - k, 0); chk(read_protect[p], 1);
      run(p, 1, 3'h0); @(posedge clk); chk(rs_cnt - k, 1); chk(read_protect[p], 0);
    end
    $display("test read ports done");
    print_verdict();
  end
endmodule : field_memory_address_pointer_tb
`default_nettype wire
